/* include/cdpc_regs.svh */
`ifndef CDPC_REGS_SVH
`define CDPC_REGS_SVH

// ************************************************************
// register offsets
// ************************************************************
`define CDPC_P1_SPECIAL_OFF 8'h1A
`define CDPC_P1_DIST_OFF 8'h1B
`define CDPC_P2_SPECIAL_OFF 8'h2A
`define CDPC_P2_DIST_OFF 8'h2B
`define CDPC_P3_DIST_RSVD_OFF 8'h3B

// ************************************************************
// special control/status field positions
// ************************************************************
`define CDPC_SHORT_BIT 7
`define CDPC_OUTCOME_HI 6
`define CDPC_OUTCOME_LO 5
`define CDPC_START_BIT 4
`define CDPC_FORCE_BIT 3
`define CDPC_PWRSAVE_BIT 2
`define CDPC_LOOP_BIT 1
`define CDPC_CNT8_BIT 0

// ************************************************************
// reset values
// ************************************************************
`define CDPC_PWRSAVE_RST 1'b1
`define CDPC_OUTCOME_RST 2'h0
`define CDPC_COUNT_RST 9'h000
`define CDPC_BYTE_RST 8'h00

`endif

/* include/cdpc_pkg.sv */
package cdpc_pkg;

	// ************************************************************
	// shared types
	// ************************************************************
	typedef enum logic [1:0]
	{
		CDPC_OUT_NORMAL = 2'h0,
		CDPC_OUT_OPEN = 2'h1,
		CDPC_OUT_SHORT = 2'h2,
		CDPC_OUT_FAILED = 2'h3
	} cdpc_outcome_t;

	typedef enum logic
	{
		CDPC_IDLE,
		CDPC_RUN
	} cdpc_state_t;

	typedef logic [8:0] cdpc_count_t;

endpackage : cdpc_pkg

/* hw/cdpc_port.sv */
`timescale 1ns/10ps
`include "cdpc_regs.svh"

module cdpc_port
	import cdpc_pkg::*;
(
	// clock and reset
	input wire logic mclk,
	input wire logic rst,
	// control register write
	input wire logic wr_en,
	input wire logic [7:0] wdata,
	// diagnostic engine
	input wire logic diag_done,
	input wire logic [1:0] diag_outcome,
	input wire logic diag_short,
	input wire logic [8:0] diag_count,
	output logic diag_start_ff,
	// phy controls
	output logic force_link_ff,
	output logic pwrsave_ff,
	output logic loopback_ff,
	// readback
	output logic [7:0] special_byte,
	output logic [7:0] dist_byte
);

	cdpc_state_t state_ff;
	cdpc_state_t nxt_state;
	logic start_ff;
	logic [1:0] outcome_ff;
	logic short_ff;
	cdpc_count_t count_ff;
	logic want_start;
	logic finish;

	// ************************************************************
	// decode
	// ************************************************************
	assign want_start = wr_en && wdata[`CDPC_START_BIT];
	assign finish = (state_ff == CDPC_RUN) && diag_done;

	always_comb
	begin
		nxt_state = state_ff;
		unique case (state_ff)
			CDPC_IDLE:
				if (want_start)
					nxt_state = CDPC_RUN;
			CDPC_RUN:
				if (finish && !want_start)
					nxt_state = CDPC_IDLE;
		endcase
	end

	// ************************************************************
	// state and results
	// ************************************************************
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			state_ff <= CDPC_IDLE;
			start_ff <= 1'b0;
			diag_start_ff <= 1'b0;
			outcome_ff <= `CDPC_OUTCOME_RST;
			short_ff <= 1'b0;
			count_ff <= `CDPC_COUNT_RST;
		end
		else
		begin
			state_ff <= nxt_state;
			start_ff <= (nxt_state == CDPC_RUN);
			diag_start_ff <= want_start && (state_ff == CDPC_IDLE || finish);
			if (finish)
			begin
				outcome_ff <= diag_outcome;
				short_ff <= diag_short;
				count_ff <= diag_count;
			end
		end
	end

	// ************************************************************
	// control bits
	// ************************************************************
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			force_link_ff <= 1'b0;
			pwrsave_ff <= `CDPC_PWRSAVE_RST;
			loopback_ff <= 1'b0;
		end
		else if (wr_en)
		begin
			force_link_ff <= wdata[`CDPC_FORCE_BIT];
			pwrsave_ff <= wdata[`CDPC_PWRSAVE_BIT];
			loopback_ff <= wdata[`CDPC_LOOP_BIT];
		end
	end

	// ************************************************************
	// readback
	// ************************************************************
	// start reads zero when done
	// count bit 8 in bit 0
	assign special_byte = {short_ff, outcome_ff, start_ff, force_link_ff,
		pwrsave_ff, loopback_ff, count_ff[8]};
	assign dist_byte = count_ff[7:0];

endmodule : cdpc_port

/* hw/cdpc_top.sv */
`timescale 1ns/10ps
`include "cdpc_regs.svh"

// Notes on behaviour
// - software sets start to run the cable test; hardware clears it after
// - start reads zero after completion; results are then valid
// - outcome 00 normal, 01 open, 10 short, 11 test failed
// - bit 7 flags a short closer than ten meters
// - nine bit count: low byte in result register, bit 8 at bit 0
// - power save on while bit is zero; resets to one
// - loopback returns line receive pair to line transmit pair
// - ports 1 and 2 at 0x1A/0x1B and 0x2A/0x2B; 0x3B reserved
// - control registers also reachable through phy management access

module cdpc_top
	import cdpc_pkg::*;
(
	// clock and reset
	mclk,
	rst,
	// switch register port
	reg_addr,
	reg_wdata,
	reg_wr,
	reg_rd,
	reg_rdata_ff,
	reg_rvalid_ff,
	// phy management access to special control/status
	miim_wr,
	miim_rd,
	miim_port,
	miim_wdata,
	miim_rdata_ff,
	// diagnostic engines, index 0 is port 1
	diag_done,
	diag_outcome,
	diag_short,
	diag_count,
	diag_start_ff,
	// phy controls
	force_link_ff,
	pwrsave_ff,
	loopback_ff
);

	localparam int NPORT = 2;

	// clock and reset
	input wire logic mclk;
	input wire logic rst;
	// switch register port
	input wire logic [7:0] reg_addr;
	input wire logic [7:0] reg_wdata;
	input wire logic reg_wr;
	input wire logic reg_rd;
	output logic [7:0] reg_rdata_ff;
	output logic reg_rvalid_ff;
	// phy management
	input wire logic miim_wr;
	input wire logic miim_rd;
	input wire logic miim_port;
	input wire logic [7:0] miim_wdata;
	output logic [7:0] miim_rdata_ff;
	// diagnostic engines
	input wire logic [NPORT-1:0] diag_done;
	input wire logic [NPORT-1:0][1:0] diag_outcome;
	input wire logic [NPORT-1:0] diag_short;
	input wire logic [NPORT-1:0][8:0] diag_count;
	output logic [NPORT-1:0] diag_start_ff;
	// phy controls
	output logic [NPORT-1:0] force_link_ff;
	output logic [NPORT-1:0] pwrsave_ff;
	output logic [NPORT-1:0] loopback_ff;

	// ************************************************************
	// address decode
	// ************************************************************
	// per port offsets
	function automatic logic [7:0] special_off(input int idx);
		special_off = (idx == 0) ? `CDPC_P1_SPECIAL_OFF
			: `CDPC_P2_SPECIAL_OFF;
	endfunction : special_off

	function automatic logic [7:0] dist_off(input int idx);
		dist_off = (idx == 0) ? `CDPC_P1_DIST_OFF : `CDPC_P2_DIST_OFF;
	endfunction : dist_off

	logic [NPORT-1:0] port_wr;
	logic [NPORT-1:0][7:0] port_wdata;
	logic [NPORT-1:0][7:0] special_byte;
	logic [NPORT-1:0][7:0] dist_byte;
	logic [NPORT-1:0][7:0] reg_hit_data;
	logic [7:0] reg_rd_value;
	logic [7:0] miim_rd_value;

	// ************************************************************
	// per port banks
	// ************************************************************
	genvar gi;
	generate
		for (gi = 0; gi < NPORT; gi++)
		begin : g_port
			logic spec_sel;
			logic dist_sel;
			logic bus_hit;
			logic miim_hit;

			assign spec_sel = (reg_addr == special_off(gi));
			assign dist_sel = (reg_addr == dist_off(gi));
			assign bus_hit = reg_wr && spec_sel;
			// management path to the same bits
			assign miim_hit = miim_wr && (miim_port == 1'(gi));
			// bus wins a same cycle collision; management write is dropped
			assign port_wr[gi] = bus_hit || miim_hit;
			assign port_wdata[gi] = bus_hit ? reg_wdata : miim_wdata;

			// reserved 0x3B and unmapped offsets fall through as zero
			assign reg_hit_data[gi] =
				spec_sel ? special_byte[gi]
				: dist_sel ? dist_byte[gi]
				: `CDPC_BYTE_RST;

			cdpc_port u_port
			(
				.mclk(mclk),
				.rst(rst),
				.wr_en(port_wr[gi]),
				.wdata(port_wdata[gi]),
				.diag_done(diag_done[gi]),
				.diag_outcome(diag_outcome[gi]),
				.diag_short(diag_short[gi]),
				.diag_count(diag_count[gi]),
				.diag_start_ff(diag_start_ff[gi]),
				.force_link_ff(force_link_ff[gi]),
				.pwrsave_ff(pwrsave_ff[gi]),
				.loopback_ff(loopback_ff[gi]),
				.special_byte(special_byte[gi]),
				.dist_byte(dist_byte[gi])
			);
		end
	endgenerate

	// ************************************************************
	// read selection
	// ************************************************************
	assign reg_rd_value = reg_hit_data[0] | reg_hit_data[1];
	assign miim_rd_value = special_byte[miim_port];

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			reg_rdata_ff <= `CDPC_BYTE_RST;
			reg_rvalid_ff <= 1'b0;
		end
		else
		begin
			reg_rvalid_ff <= reg_rd;
			if (reg_rd)
				reg_rdata_ff <= reg_rd_value;
		end
	end

	// management reads see only the special control/status byte
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
			miim_rdata_ff <= `CDPC_BYTE_RST;
		else if (miim_rd)
			miim_rdata_ff <= miim_rd_value;
	end

endmodule : cdpc_top

/* verif/cdpc_monitor.sv */
`timescale 1ns/10ps
// ****
// port checker
// ****
module cdpc_monitor
	import cdpc_pkg::*;
(
	// clock and reset
	input wire logic mclk,
	input wire logic rst,
	// register port
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata_ff,
	input wire logic reg_rvalid_ff,
	// management port
	input wire logic miim_wr,
	input wire logic miim_rd,
	input wire logic miim_port,
	input wire logic [7:0] miim_wdata,
	input wire logic [7:0] miim_rdata_ff,
	// engine and phy
	input wire logic [1:0] diag_done,
	input wire logic [1:0] diag_start_ff,
	input wire logic [1:0] force_link_ff,
	input wire logic [1:0] pwrsave_ff,
	input wire logic [1:0] loopback_ff
);
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	rd_pulse_a: assert property (reg_rd |=> reg_rvalid_ff)
		else $error("read answer missing");
	rd_only_a: assert property (!reg_rd |=> !reg_rvalid_ff)
		else $error("read answer without request");
	rsvd_zero_a: assert property (reg_rd && reg_addr == 8'h3B
		|=> reg_rdata_ff == 8'h00) else $error("reserved slot not zero");
	start_once_a: assert property (diag_start_ff[0]
		|=> !diag_start_ff[0]) else $error("start pulse too long");
	start_bit_a: assert property (diag_start_ff[0] && !diag_done[0]
		##1 reg_rd && reg_addr == 8'h1A |=> reg_rdata_ff[4])
		else $error("start bit not set while running");
	pwr_read_a: assert property (reg_rd && reg_addr == 8'h1A
		|=> reg_rdata_ff[2] == $past(pwrsave_ff[0]))
		else $error("power save readback wrong");
	loop_wr_a: assert property (reg_wr && reg_addr == 8'h2A
		|=> loopback_ff[1] == $past(reg_wdata[1]))
		else $error("loopback not written");
	miim_wr_a: assert property (miim_wr && miim_port &&
		!(reg_wr && reg_addr == 8'h2A)
		|=> force_link_ff[1] == $past(miim_wdata[3]))
		else $error("management write lost");
	miim_rd_a: assert property (miim_rd
		|=> miim_rdata_ff[2] == $past(pwrsave_ff[miim_port]))
		else $error("management read wrong");
	cover property (diag_done[0] && !diag_start_ff[0]);
	cover property (miim_wr && reg_wr);
	cover property (reg_rd && reg_addr == 8'h3B);
	cover property (diag_done[0] && reg_wr && reg_addr == 8'h1A);
endmodule : cdpc_monitor

bind cdpc_top cdpc_monitor i_mon (.mclk, .rst, .reg_addr, .reg_wr, .reg_rd,
	.reg_wdata, .reg_rdata_ff, .reg_rvalid_ff, .miim_wr, .miim_rd, .miim_port,
	.miim_wdata, .miim_rdata_ff, .diag_done, .diag_start_ff, .force_link_ff,
	.pwrsave_ff, .loopback_ff);

/* verif/tb_top.sv */
`timescale 1ns/10ps
module tb_top
	import cdpc_pkg::*;
;
	typedef struct {logic [7:0] a, d, e;} cdpc_row_t;
	logic mclk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
	logic miim_wr = 1'b0, miim_rd = 1'b0, miim_port = 1'b0, reg_rvalid_ff;
	logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, miim_wdata = 8'h00;
	logic [7:0] reg_rdata_ff, miim_rdata_ff, b, x;
	logic [1:0] diag_done = 2'h0, diag_short = 2'h0, o;
	logic [1:0] diag_start_ff, force_link_ff, pwrsave_ff, loopback_ff;
	logic [1:0][1:0] diag_outcome = 4'h0;
	logic [1:0][8:0] diag_count = 18'h00000;
	logic [8:0] c, k;
	int n_fail = 0, samples_checked = 0, p;
	// control bits read back as written; read-only and reserved places keep zero
	cdpc_row_t rows [6] = '{'{8'h1A, 8'h0A, 8'h0A}, '{8'h2A, 8'h06, 8'h06},
		'{8'h1B, 8'hFF, 8'h00}, '{8'h3B, 8'hFF, 8'h00},
		'{8'h1A, 8'hE1, 8'h00}, '{8'h2B, 8'hFF, 8'h00}};
	always #10 mclk = ~mclk;
	cdpc_top i_dut (.mclk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
		.reg_rdata_ff, .reg_rvalid_ff, .miim_wr, .miim_rd, .miim_port,
		.miim_wdata, .miim_rdata_ff, .diag_done, .diag_outcome, .diag_short,
		.diag_count, .diag_start_ff, .force_link_ff, .pwrsave_ff, .loopback_ff);
	task chk(input logic [8:0] s, input logic [8:0] e);
		samples_checked++;
		if (s !== e)
		begin
			n_fail++;
			$display("ERROR %0t got %h want %h", $time, s, e);
		end
	endtask : chk
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge mclk);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge mclk);
		reg_wr = 1'b0;
	endtask : wr
	task rd(input logic [7:0] a);
		@(negedge mclk);
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge mclk);
		reg_rd = 1'b0;
		chk(reg_rvalid_ff, 1);
	endtask : rd
	// released engine lines show the inverse, not the last value
	task diag(input int q, input logic [1:0] r, input logic [8:0] k);
		@(negedge mclk);
		diag_done[q] = 1'b1;
		diag_outcome[q] = r;
		diag_short[q] = r[0];
		diag_count[q] = k;
		@(negedge mclk);
		diag_done[q] = 1'b0;
		diag_outcome[q] = ~r;
		diag_short[q] = ~r[0];
		diag_count[q] = ~k;
	endtask : diag
	task end_of_test;
		if (n_fail == 0 && samples_checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : end_of_test
	initial
	begin
		#100000;
		n_fail++;
		end_of_test();
	end
	initial
	begin
		repeat (6) @(negedge mclk);
		rst = 1'b0;
		foreach (rows[i])
		begin
			wr(rows[i].a, rows[i].d);
			rd(rows[i].a);
			chk(reg_rdata_ff, rows[i].e);
		end
		chk(pwrsave_ff, 2'b10);
		chk(loopback_ff, 2'b10);
		for (int i = 0; i < 8; i++)
		begin
			p = i % 2;
			o = 2'(i / 2);
			b = p ? 8'h2A : 8'h1A;
			c = 9'h155 ^ 9'(i * 37);
			wr(b, 8'h14);
			chk(diag_start_ff[p], 1);
			rd(b);
			chk(reg_rdata_ff[4], 1);
			diag(p, o, c);
			rd(b);
			x = {o[0], o, 1'b0, 3'b010, c[8]};
			chk(reg_rdata_ff, x);
			k[8] = reg_rdata_ff[0];
			rd(b + 8'h01);
			chk(reg_rdata_ff, c[7:0]);
			k[7:0] = reg_rdata_ff;
			chk(k, c);
		end
		wr(8'h2A, 8'hE5);
		rd(8'h2A);
		chk(reg_rdata_ff, x);
		@(negedge mclk);
		miim_port = 1'b1;
		miim_wdata = 8'h08;
		miim_wr = 1'b1;
		@(negedge mclk);
		miim_wr = 1'b0;
		miim_rd = 1'b1;
		chk(force_link_ff[1], 1);
		@(negedge mclk);
		miim_rd = 1'b0;
		chk(miim_rdata_ff[3], 1);
		// bus write wins over a management write to the same port
		miim_wr = 1'b1;
		wr(8'h2A, 8'h00);
		miim_wr = 1'b0;
		chk(force_link_ff[1], 0);
		// start write of zero does not abort; start with done restarts
		wr(8'h1A, 8'h14);
		wr(8'h1A, 8'h04);
		rd(8'h1A);
		chk(reg_rdata_ff[4], 1);
		@(negedge mclk);
		reg_addr = 8'h1A;
		reg_wdata = 8'h14;
		reg_wr = 1'b1;
		diag_done[0] = 1'b1;
		diag_outcome[0] = 2'h1;
		diag_short[0] = 1'b0;
		diag_count[0] = 9'h1C3;
		@(negedge mclk);
		reg_wr = 1'b0;
		diag_done[0] = 1'b0;
		chk(diag_start_ff[0], 1);
		rd(8'h1A);
		chk(reg_rdata_ff, 8'h35);
		rd(8'h1B);
		chk(reg_rdata_ff, 8'hC3);
		rst = 1'b1;
		@(negedge mclk);
		rst = 1'b0;
		chk(pwrsave_ff, 2'b11);
		rd(8'h1A);
		chk(reg_rdata_ff, 8'h04);
		rd(8'h1B);
		chk(reg_rdata_ff, 8'h00);
		end_of_test();
	end
endmodule : tb_top
